// ### logic/sfec_pkg.sv
// Package: shared constants for the serial flash erase command path
`default_nettype none
package sfec_pkg;
  // ---------------------------------------------------------------
  // Opcodes and frame layout
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [5:0] FRAME_BITS_6 = 6'h20;
  localparam logic [5:0] FRAME_LAST_6 = 6'h1f;
  // Page field position inside the 24-bit address
  localparam int unsigned PAGE_LSB_264 = 9;
  localparam int unsigned PAGE_LSB_256 = 8;
  localparam int unsigned PAGE_BITS = 11;
  localparam int unsigned BYTE_BITS = 9;
  localparam logic [8:0] LAST_BYTE_264 = 9'h107;
  localparam logic [8:0] LAST_BYTE_256 = 9'h0ff;
  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam logic [10:0] BLOCK_MASK = 11'h7f8;
  localparam logic [10:0] BLOCK_SPAN = 11'h007;
  localparam logic [10:0] SECT0A_LAST = 11'h007;
  localparam logic [10:0] SECT0B_FIRST = 11'h008;
  localparam logic [10:0] SECT_SPAN = 11'h0ff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Link levels at rest {cs_n, sck, si}: chip select high, clock and data low
  localparam logic [2:0] LINK_IDLE = 3'h4;
  // ---------------------------------------------------------------
  // Timing: maximum erase times in ns, clock 100 MHz
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PAGE_ERASE_TIME_MAX_NS = 50000;
  localparam int unsigned BLOCK_ERASE_TIME_MAX_NS = 100000;
  localparam int unsigned SECTOR_ERASE_TIME_MAX_NS = 5000000;
  localparam int unsigned PE_CYC = PAGE_ERASE_TIME_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned BE_CYC = BLOCK_ERASE_TIME_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned SE_CYC = SECTOR_ERASE_TIME_MAX_NS * CLK_MHZ / 1000;
  // Host serial clock half period in core cycles (80 ns period)
  localparam int unsigned SCK_HALF_CYC = 4;
  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SFEC_ERS_IDLE = 2'b00,
    SFEC_ERS_WRITE = 2'b01,
    SFEC_ERS_READ = 2'b10,
    SFEC_ERS_CHECK = 2'b11
  } sfec_ers_t;
  typedef enum logic [1:0] {
    SFEC_HST_IDLE = 2'b00,
    SFEC_HST_SHIFT = 2'b01,
    SFEC_HST_END = 2'b10
  } sfec_hst_t;
endpackage : sfec_pkg
`default_nettype wire

// ### logic/sfec_if.sv
// Interface: serial link between erase host and flash device
`default_nettype none
interface sfec_if;
  logic sck;
  logic cs_n;
  logic si;
  modport dev (input sck, input cs_n, input si);
  modport host (output sck, output cs_n, output si);
endinterface : sfec_if
`default_nettype wire

// ### logic/sfec_device.sv
// Flash device end: erase frame decoder and self-timed erase sequencer
// Function
// - 264 mode page erase: 81h, page bits 19..9
// - 256 mode page erase: 81h, page at 18..8
// - Page erase leaves every bit at one
// - Erase self-timed, busy throughout, bounded by maximum
// - Verify each byte, flag erase error on fail
// - Block erase 50h covers eight aligned pages
// - 264 mode block number at page bits 10..3
// - 256 mode block number at bits 18..11
// - Block index from page 10..3, ignore 2..0
// - Chip select rise starts whole block erase
// - Sector erase 7Ch erases one of nine
// - Upper bits zero: bit 3 picks 0a/0b
// - 264 mode sector number at page 10..8
// - 256 mode sector number at bits 18..16
// - Any address inside sector; erase sector 1..7
// - 256 mode linear address is 19 bits
`default_nettype none
module sfec_device #(
  parameter int unsigned PE_CYC = sfec_pkg::PE_CYC,
  parameter int unsigned BE_CYC = sfec_pkg::BE_CYC,
  parameter int unsigned SE_CYC = sfec_pkg::SE_CYC
) (
  sfec_if.dev lnk,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic page_264,
  input wire logic [7:0] arr_rdata,
  output logic busy,
  output logic erase_program_error_flag,
  output logic arr_en,
  output logic arr_we,
  output logic [sfec_pkg::PAGE_BITS-1:0] arr_page,
  output logic [sfec_pkg::BYTE_BITS-1:0] arr_byte,
  output logic [7:0] arr_wdata
);
  import sfec_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sck_prev_ff;
  logic cs_prev_ff;
  logic sck_s;
  logic cs_s;
  logic si_s;
  logic sck_rise;
  logic cs_rise;

  // Two flops on sck, chip select and serial data; reset to idle levels so no false edge follows
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= LINK_IDLE;
      sync2_ff <= LINK_IDLE;
    end else begin
      sync1_ff <= {lnk.cs_n, lnk.sck, lnk.si};
      sync2_ff <= sync1_ff;
    end
  end

  assign cs_s = sync2_ff[2];
  assign sck_s = sync2_ff[1];
  assign si_s = sync2_ff[0];

  // Previous levels for edge finding
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_s;
      cs_prev_ff <= cs_s;
    end
  end

  assign sck_rise = sck_s && !sck_prev_ff;
  assign cs_rise = cs_s && !cs_prev_ff;

  // ---------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_ff;
  logic [5:0] bit_cnt_ff;

  // Shift MSB first on each sck rise while selected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
      bit_cnt_ff <= 6'h00;
    end else if (cs_s) begin
      bit_cnt_ff <= 6'h00;
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[FRAME_BITS-2:0], si_s};
      if (bit_cnt_ff <= FRAME_BITS_6) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [7:0] op;
  logic [23:0] addr;
  logic [PAGE_BITS-1:0] page_sel;
  logic [PAGE_BITS-1:0] first_page;
  logic [PAGE_BITS-1:0] last_page;
  logic [31:0] limit_cyc;
  logic op_known;
  logic start;

  assign op = shift_ff[31:24];
  assign addr = shift_ff[23:0];

  // Page field: 264 mode bits 19..9, 256 mode linear bits 18..8
  assign page_sel = page_264 ? addr[PAGE_LSB_264 +: PAGE_BITS]
                             : addr[PAGE_LSB_256 +: PAGE_BITS];

  // Page range and time bound per opcode
  always_comb begin
    first_page = page_sel;
    last_page = page_sel;
    limit_cyc = PE_CYC;
    op_known = 1'b1;
    unique case (op)
      OP_PAGE_ERASE: begin
        limit_cyc = PE_CYC;
      end
      OP_BLOCK_ERASE: begin
        first_page = page_sel & BLOCK_MASK;
        last_page = (page_sel & BLOCK_MASK) | BLOCK_SPAN;
        limit_cyc = BE_CYC;
      end
      OP_SECTOR_ERASE: begin
        limit_cyc = SE_CYC;
        // Only pages 0..7 pick the small sector; any other page below 256 lies in the second one
        if (page_sel[10:3] == 8'h00) begin
          first_page = '0;
          last_page = SECT0A_LAST;
        end else if (page_sel[10:8] == 3'h0) begin
          first_page = SECT0B_FIRST;
          last_page = SECT_SPAN;
        end else begin
          first_page = {page_sel[10:8], 8'h00};
          last_page = {page_sel[10:8], 8'h00} | SECT_SPAN;
        end
      end
      default: begin
        op_known = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Erase sequencer
  // ---------------------------------------------------------------
  sfec_ers_t state_ff;
  logic [PAGE_BITS-1:0] page_ff;
  logic [PAGE_BITS-1:0] last_page_ff;
  logic [BYTE_BITS-1:0] byte_ff;
  logic [BYTE_BITS-1:0] last_byte_ff;
  logic [31:0] timer_ff;
  logic [31:0] limit_ff;
  logic last_byte;
  logic timeout;

  // Start only on chip select rise after exactly 32 bits
  assign start = cs_rise && (bit_cnt_ff == FRAME_BITS_6) && op_known && (state_ff == SFEC_ERS_IDLE);
  assign last_byte = (byte_ff == last_byte_ff) && (page_ff == last_page_ff);
  assign timeout = (timer_ff >= limit_ff);

  // Write, read back, check each byte of the range
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SFEC_ERS_IDLE;
      page_ff <= '0;
      last_page_ff <= '0;
      byte_ff <= '0;
      last_byte_ff <= LAST_BYTE_256;
    end else begin
      unique case (state_ff)
        SFEC_ERS_IDLE: begin
          if (start) begin
            state_ff <= SFEC_ERS_WRITE;
            page_ff <= first_page;
            last_page_ff <= last_page;
            byte_ff <= '0;
            last_byte_ff <= page_264 ? LAST_BYTE_264 : LAST_BYTE_256;
          end
        end
        SFEC_ERS_WRITE: begin
          state_ff <= SFEC_ERS_READ;
        end
        SFEC_ERS_READ: begin
          state_ff <= SFEC_ERS_CHECK;
        end
        SFEC_ERS_CHECK: begin
          if (last_byte || timeout) begin
            state_ff <= SFEC_ERS_IDLE;
          end else begin
            state_ff <= SFEC_ERS_WRITE;
            if (byte_ff == last_byte_ff) begin
              byte_ff <= '0;
              page_ff <= page_ff + 11'h001;
            end else begin
              byte_ff <= byte_ff + 9'h001;
            end
          end
        end
      endcase
    end
  end

  // Time bound for the running erase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= '0;
      limit_ff <= '0;
    end else if (start) begin
      timer_ff <= '0;
      limit_ff <= limit_cyc;
    end else if (state_ff != SFEC_ERS_IDLE) begin
      timer_ff <= timer_ff + 32'h1;
    end
  end

  // Busy from start to end of the erase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (state_ff == SFEC_ERS_CHECK && (last_byte || timeout)) begin
      busy <= 1'b0;
    end
  end

  // Error flag: cleared by a new erase, set by a bad byte or overrun
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_program_error_flag <= 1'b0;
    end else if (state_ff == SFEC_ERS_CHECK && (arr_rdata != ERASED_BYTE || (timeout && !last_byte))) begin
      erase_program_error_flag <= 1'b1;
    end else if (start) begin
      erase_program_error_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Array port, registered
  // ---------------------------------------------------------------
  // Drive write of all ones, then a read for the
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_en <= 1'b0;
      arr_we <= 1'b0;
      arr_page <= '0;
      arr_byte <= '0;
      arr_wdata <= ERASED_BYTE;
    end else begin
      arr_en <= (state_ff == SFEC_ERS_WRITE) || (state_ff == SFEC_ERS_READ);
      arr_we <= (state_ff == SFEC_ERS_WRITE);
      arr_page <= page_ff;
      arr_byte <= byte_ff;
      arr_wdata <= ERASED_BYTE;
    end
  end
endmodule : sfec_device
`default_nettype wire

// ### logic/sfec_host.sv
// Host end: sends one 32-bit erase frame per command over the serial link
`default_nettype none
module sfec_host #(
  parameter int unsigned HALF_CYC = sfec_pkg::SCK_HALF_CYC
) (
  sfec_if.host lnk,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  output logic cmd_ready,
  output logic cmd_done
);
  import sfec_pkg::*;

  // ---------------------------------------------------------------
  // Serial clock divider
  // ---------------------------------------------------------------
  sfec_hst_t state_ff;
  logic [7:0] div_ff;
  logic tick;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [5:0] bit_ff;
  logic sck_ff;
  logic cs_n_ff;

  assign tick = (div_ff == 8'(HALF_CYC - 1));

  // Half period counter, restarted with each frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 8'h00;
    end else if (state_ff == SFEC_HST_IDLE || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // Opcode then address, MSB first, data changes while sck low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SFEC_HST_IDLE;
      shift_ff <= '0;
      bit_ff <= 6'h00;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      unique case (state_ff)
        SFEC_HST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            shift_ff <= {cmd_op, cmd_addr};
            bit_ff <= 6'h00;
            cs_n_ff <= 1'b0;
            cmd_ready <= 1'b0;
            state_ff <= SFEC_HST_SHIFT;
          end
        end
        SFEC_HST_SHIFT: begin
          if (tick) begin
            if (!sck_ff) begin
              sck_ff <= 1'b1;
            end else begin
              sck_ff <= 1'b0;
              if (bit_ff == FRAME_LAST_6) begin
                state_ff <= SFEC_HST_END;
              end else begin
                shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};
                bit_ff <= bit_ff + 6'h01;
              end
            end
          end
        end
        SFEC_HST_END: begin
          if (tick) begin
            cs_n_ff <= 1'b1; // Rise after full frame starts the erase
            cmd_done <= 1'b1;
            cmd_ready <= 1'b1;
            state_ff <= SFEC_HST_IDLE;
          end
        end
        default: begin
          state_ff <= SFEC_HST_IDLE;
        end
      endcase
    end
  end

  assign lnk.sck = sck_ff;
  assign lnk.cs_n = cs_n_ff;
  assign lnk.si = shift_ff[FRAME_BITS-1];
endmodule : sfec_host
`default_nettype wire

// ### sim/sfec_assertions.sv
// Checker: link framing and erase sequencing properties
`default_nettype none
module sfec_assertions #(
  parameter int unsigned MAX_CYC = 10016
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic busy,
  input wire logic erase_program_error_flag,
  input wire logic arr_en,
  input wire logic arr_we,
  input wire logic [sfec_pkg::PAGE_BITS-1:0] arr_page,
  input wire logic [sfec_pkg::BYTE_BITS-1:0] arr_byte,
  input wire logic [7:0] arr_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfec_pkg::*;
  logic [3:0] cs_hi_ff;
  logic [31:0] busy_cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since chip select went high, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cs_hi_ff <= 4'hf;
    else if (!cs_n) cs_hi_ff <= 4'h0;
    else if (cs_hi_ff != 4'hf) cs_hi_ff <= cs_hi_ff + 4'h1;
  end
  // Length of the current busy period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_ff <= 32'h0;
    else busy_cnt_ff <= busy ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock active outside a frame");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("chip select gap too short");
  sck_half_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase wrong");
  si_hold_a: assert property (sck && !cs_n |-> $stable(si))
    else $error("serial data moved while clock high");
  busy_start_a: assert property ($rose(busy) |-> cs_hi_ff inside {[4'h2:4'h6]})
    else $error("erase started away from chip select rise");
  erased_data_a: assert property (arr_en && arr_we |-> arr_wdata == 8'hff)
    else $error("erase wrote a value other than all ones");
  verify_read_a: assert property (arr_en && arr_we |=>
    arr_en && !arr_we && $stable(arr_page) && $stable(arr_byte))
    else $error("erased byte not read back");
  array_busy_a: assert property (arr_en |-> busy)
    else $error("array access while not busy");
  flag_set_a: assert property ($rose(erase_program_error_flag) |-> $past(busy))
    else $error("error flag set outside an erase");
  busy_bound_a: assert property (busy_cnt_ff <= MAX_CYC)
    else $error("erase exceeded its time bound");
endmodule : sfec_assertions
`default_nettype wire

// ### sim/testbench.sv
// Testbench: both link ends, array model and erase checks
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfec_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic page_264 = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [7:0] arr_rdata = 8'h00;
  logic cmd_ready, cmd_done, busy, erase_program_error_flag, arr_en, arr_we;
  logic [10:0] arr_page;
  logic [8:0] arr_byte;
  logic [7:0] arr_wdata;
  logic [11:0] bad_pg = 12'hfff;
  int bad_count = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int first_pg, last_pg;
  bit ers[int];
  sfec_if lnk ();
  sfec_host i_sfec_host (.lnk(lnk), .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .cmd_done(cmd_done));
  sfec_device #(.SE_CYC(7000)) i_sfec_device (.lnk(lnk), .core_clk(core_clk), .rst_n(rst_n),
    .page_264(page_264), .arr_rdata(arr_rdata), .busy(busy),
    .erase_program_error_flag(erase_program_error_flag), .arr_en(arr_en), .arr_we(arr_we),
    .arr_page(arr_page), .arr_byte(arr_byte), .arr_wdata(arr_wdata));
  sfec_assertions #(.MAX_CYC(10016)) i_sfec_assertions (.core_clk(core_clk), .rst_n(rst_n),
    .sck(lnk.sck), .cs_n(lnk.cs_n), .si(lnk.si), .busy(busy),
    .erase_program_error_flag(erase_program_error_flag), .arr_en(arr_en), .arr_we(arr_we),
    .arr_page(arr_page), .arr_byte(arr_byte), .arr_wdata(arr_wdata));
  // Clock: 100 MHz
  initial forever #5 core_clk = ~core_clk;
  // Array model: records each erase write at the edge that samples it
  always @(posedge core_clk) begin
    if (arr_en && arr_we) begin
      ers[{arr_page, arr_byte}] = 1'b1;
      if (wr_cnt == 0) first_pg = arr_page;
      last_pg = arr_page;
      wr_cnt++;
    end
  end
  // Read data answers the read strobe before the edge at which the device checks it;
  // erased bytes read back as ones unless the page is marked bad
  always @(negedge core_clk) begin
    arr_rdata <= (arr_en && !arr_we && ers.exists({arr_page, arr_byte})
      && {1'b0, arr_page} != bad_pg) ? 8'hff : 8'h00;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // Page field with random ignored bits around it
  function automatic logic [23:0] addr(input logic [10:0] pg);
    return page_264 ? {4'($urandom), pg, 9'($urandom)} : {5'($urandom), pg, 8'($urandom)};
  endfunction : addr
  task automatic wb(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) @(negedge core_clk);
    chk("busy", busy, v);
  endtask : wb
  task automatic send(input logic [7:0] op, input logic [23:0] a);
    repeat (10) @(negedge core_clk);
    chk("ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 400 && cmd_done !== 1'b1; i++) @(negedge core_clk);
    chk("frame done", cmd_done, 1'b1);
  endtask : send
  // One erase; npg 0 means the time bound cuts it short
  task automatic erase(input logic [7:0] op, input logic [10:0] pg, input int nfirst,
                       input int npg, input logic err, input bit dup);
    wr_cnt = 0;
    ers.delete();
    send(op, addr(pg));
    wb(1'b1, 400);
    if (dup) send(op, addr(pg ^ 11'h001));
    wb(1'b0, 12000);
    chk("first page", first_pg, nfirst);
    if (npg > 0) begin
      chk("last page", last_pg, nfirst + npg - 1);
      chk("writes", wr_cnt, npg * (page_264 ? 264 : 256));
    end
    chk("error flag", erase_program_error_flag, err);
  endtask : erase
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] pg;
    void'($urandom(79692));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    pg = 11'($urandom);
    erase(OP_PAGE_ERASE, pg, pg, 1, 1'b0, 1'b1);
    page_264 = 1'b1;
    pg = 11'($urandom);
    erase(OP_PAGE_ERASE, pg, pg, 1, 1'b0, 1'b0);
    bad_pg = {1'b0, pg};
    erase(OP_PAGE_ERASE, pg, pg, 1, 1'b1, 1'b0);
    bad_pg = 12'hfff;
    for (int m = 0; m < 2; m++) begin
      page_264 = m[0];
      pg = 11'($urandom);
      erase(OP_BLOCK_ERASE, pg, pg & BLOCK_MASK, 8, 1'b0, 1'b0);
      erase(OP_SECTOR_ERASE, {7'h00, m[0], 3'($urandom)}, m * 8, 8 - m * 8, m[0], 1'b0);
      pg = {3'($urandom % 7 + 1), 8'($urandom)};
      erase(OP_SECTOR_ERASE, pg, {pg[10:8], 8'h00}, 0, 1'b1, 1'b0);
    end
    erase(OP_SECTOR_ERASE, {3'h0, 4'($urandom) | 4'h1, 4'h0}, 8, 0, 1'b1, 1'b0);
    wr_cnt = 0;
    send(8'h02, addr(pg));
    repeat (400) @(negedge core_clk);
    chk("busy", busy, 1'b0);
    chk("writes", wr_cnt, 0);
    test_done();
  end
  // Watchdog: the sequence needs a little over half this span
  initial begin
    #900000;
    bad_count++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
